// [bench/pa_ramp_control_tb.sv]
// Self-checking testbench of the PA ramp controller with a behavioural ramp model.
`timescale 1ns/100ps
module pa_ramp_control_tb
    import pa_ramp_pkg::*;
;
    logic pclk, presetn, psel, penable, pwrite, ramp_up_req, pready, ramp_busy;
    logic [8:0] paddr, power_level_adjust, ramp_level;
    logic [31:0] pwdata, prdata, rd, seed;
    int num_errors, compares, cfg, r, f, lvl, tick, step, n;

    pa_ramp_ctrl dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .ramp_up_req(ramp_up_req),
        .power_level_adjust(power_level_adjust), .ramp_level(ramp_level), .ramp_busy(ramp_busy));

    initial
    begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic end_sim;
        $display("Errors %0d in %0d compares", num_errors, compares);
        if (num_errors == 0 && compares > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp)
        begin
            num_errors++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, got);
        end
    endtask

    // Ramp durations may differ from the model by the phase of the free-running base tick.
    task automatic chk_time(input string nm, input int exp, input int got, input int tol);
        compares++;
        if (got < exp - tol || got > exp + tol)
        begin
            num_errors++;
            $display("MISMATCH %s expected %0d seen %0d", nm, exp, got);
        end
    endtask

    task automatic apb(input logic wr, input logic [6:0] idx, input logic [7:0] wd, output logic [31:0] q);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= {idx, 2'b00};
        pwdata <= {24'h00_0000, wd};
        @(posedge pclk);
        penable <= 1'b1;
        do
        begin
            @(posedge pclk);
            k++;
        end
        while (pready !== 1'b1 && k < 16);
        q = prdata;
        psel <= 1'b0;
        penable <= 1'b0;
        if (k >= 16)
        begin
            num_errors++;
            end_sim;
        end
    endtask

    task automatic wr(input logic [6:0] idx, input logic [7:0] d);
        logic [31:0] unused;
        apb(1'b1, idx, d, unused);
    endtask

    task automatic rdchk(input string nm, input logic [6:0] idx, input logic [31:0] exp);
        apb(1'b0, idx, 8'h00, rd);
        chk(nm, exp, rd);
    endtask

    task automatic ramp(input logic up, output int cnt);
        cnt = 0;
        @(posedge pclk);
        ramp_up_req <= up;
        do
        begin
            @(posedge pclk);
            cnt++;
        end
        while ((ramp_busy !== 1'b0 || cnt < 3) && cnt < 20000);
        if (cnt >= 20000)
        begin
            num_errors++;
            end_sim;
        end
    endtask

    initial
    begin
        presetn = 1'b0;
        {psel, penable, pwrite, ramp_up_req} = 4'h0;
        paddr = 9'h000;
        pwdata = 32'h0000_0000;
        power_level_adjust = 9'h000;
        num_errors = 0;
        compares = 0;
        seed = 32'h0001_3208;
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        wr(IDX_BANK_SEL, RAMP_BANK);
        rdchk("tick_step_reset", IDX_TICK_STEP, {29'h0, TICK_STEP_RST});
        rdchk("rise_reset", IDX_RISE, {25'h0, RISE_RST});
        rdchk("fall_reset", IDX_FALL, {25'h0, FALL_RST});
        wr(7'h44, 8'hff);
        rdchk("reserved", 7'h44, 32'h0000_0000);
        wr(IDX_TICK_STEP, 8'hff);
        rdchk("tick_step_fields", IDX_TICK_STEP, 32'h0000_0007);
        wr(IDX_BANK_SEL, STATUS_BANK);
        wr(IDX_RISE, 8'h55);
        wr(IDX_BANK_SEL, RAMP_BANK);
        rdchk("rise_bank_gate", IDX_RISE, {25'h0, RISE_RST});
        for (cfg = 0; cfg < 8; cfg++)
        begin
            r = 2 + int'(seed % 4);
            seed = lfsr(seed);
            f = 2 + int'(seed % 4);
            seed = lfsr(seed);
            lvl = 9 + int'(seed % 40);
            seed = lfsr(seed);
            tick = cfg[2] ? 32 : 2;
            step = 1 << cfg[1:0];
            wr(IDX_TICK_STEP, cfg[7:0]);
            wr(IDX_RISE, r[7:0]);
            wr(IDX_FALL, f[7:0]);
            power_level_adjust <= lvl[8:0];
            ramp(1'b1, n);
            chk_time("rise_time", tick * r * ((lvl + step - 1) / step), n, 2 * tick + 4);
            chk("level_up", lvl, {23'h0, ramp_level});
            repeat (40) @(posedge pclk);
            chk("level_hold", lvl, {23'h0, ramp_level});
            chk("busy_idle", 32'h0000_0000, {31'h0, ramp_busy});
            ramp(1'b0, n);
            chk_time("fall_time", tick * f * ((lvl + step - 1) / step), n, 2 * tick + 4);
            chk("level_down", 32'h0000_0000, {23'h0, ramp_level});
        end
        // A level above 255 exercises the ninth counter bit and the status readback.
        power_level_adjust <= 9'h105;
        ramp(1'b1, n);
        chk_time("rise_time_wide", tick * r * 33, n, 2 * tick + 4);
        chk("level_wide", 32'h0000_0105, {23'h0, ramp_level});
        wr(IDX_BANK_SEL, STATUS_BANK);
        rdchk("status_level_lo", IDX_LEVEL_LO, 32'h0000_0005);
        rdchk("status_level_hi", IDX_LEVEL_HI, 32'h0000_0001);
        wr(IDX_BANK_SEL, 8'h05);
        rdchk("other_bank", IDX_TICK_STEP, 32'h0000_0000);
        end_sim;
    end
endmodule

// [hdl/pa_ramp_ctrl.sv]
// APB register file and ramp counter of the PA ramp controller.
//
// Design decision made here: the APB register port.
`timescale 1ns/100ps
module pa_ramp_ctrl
    import pa_ramp_pkg::*;
(
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [8:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    // Ramp control.
    input wire logic ramp_up_req,
    input wire logic [8:0] power_level_adjust,
    output logic [8:0] ramp_level,
    output logic ramp_busy
);
    typedef struct packed {
        logic [7:0] bank;
        logic [2:0] tick_step;
        logic [6:0] rise;
        logic [6:0] fall;
        logic [8:0] cnt;
        logic [6:0] intv;
        logic dir_up;
        logic busy;
        logic pready;
        logic [31:0] prdata;
    } ramp_state_t;

    ramp_state_t q, d;
    logic tick;
    logic [6:0] idx;
    logic wr_en;
    logic [9:0] step;
    logic [9:0] up_sum;
    logic [6:0] setting;
    logic advance;
    logic [7:0] rd_val;

    ramp_tick_div u_tick
    (
        .pclk(pclk),
        .presetn(presetn),
        .slow_sel(q.tick_step[TICK_SEL_BIT]),
        .tick(tick)
    );

    assign idx = paddr[8:2];
    assign wr_en = psel && penable && q.pready && pwrite;
    assign step = 10'd1 << q.tick_step[STEP_LSB +: 2];
    assign up_sum = {1'b0, q.cnt} + step;
    assign setting = q.dir_up ? q.rise : q.fall;

    always_comb
    begin
        rd_val = 8'h00;
        if (idx == IDX_BANK_SEL)
            rd_val = q.bank;
        else if (q.bank == RAMP_BANK)
        begin
            // Everything else in the ramp bank reads as zero.
            unique case (idx)
                IDX_TICK_STEP: rd_val = {5'h00, q.tick_step};
                IDX_RISE: rd_val = {1'b0, q.rise};
                IDX_FALL: rd_val = {1'b0, q.fall};
                default: rd_val = 8'h00;
            endcase
        end
        else if (q.bank == STATUS_BANK)
        begin
            if (idx == IDX_LEVEL_LO)
                rd_val = q.cnt[7:0];
            else if (idx == IDX_LEVEL_HI)
                rd_val = {6'h00, q.busy, q.cnt[8]};
        end
    end

    always_comb
    begin
        d = q;
        // Zero-wait APB: ready is raised in every access phase.
        d.pready = psel && !penable;
        if (psel && !penable && !pwrite)
            d.prdata = {24'h00_0000, rd_val};
        if (wr_en)
        begin
            if (idx == IDX_BANK_SEL)
                d.bank = pwdata[7:0];
            else if (q.bank == RAMP_BANK)
            begin
                if (idx == IDX_TICK_STEP)
                    d.tick_step = pwdata[2:0];
                else if (idx == IDX_RISE)
                    d.rise = pwdata[6:0];
                else if (idx == IDX_FALL)
                    d.fall = pwdata[6:0];
            end
        end

        // A step is taken every 'setting' ticks; a setting of zero steps on every tick.
        advance = 1'b0;
        if (ramp_up_req != q.dir_up)
        begin
            d.dir_up = ramp_up_req;
            d.intv = 7'h00;
        end
        else if (tick)
        begin
            if ({1'b0, q.intv} + 8'd1 >= {1'b0, setting})
            begin
                d.intv = 7'h00;
                advance = 1'b1;
            end
            else
            begin
                d.intv = q.intv + 7'd1;
            end
        end

        if (advance)
        begin
            if (q.dir_up)
            begin
                // Climbing from zero to the power level takes level/step steps, rounded up; the last step is clamped to the level.
                if (q.cnt < power_level_adjust)
                    d.cnt = (up_sum >= {1'b0, power_level_adjust}) ? power_level_adjust : up_sum[8:0];
            end
            else if ({1'b0, q.cnt} <= step)
                d.cnt = 9'h000;
            else
                d.cnt = q.cnt - step[8:0];
        end
        d.busy = d.dir_up ? (d.cnt < power_level_adjust) : (d.cnt != 9'h000);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            q <= '0;
            q.bank <= BANK_SEL_RST;
            q.tick_step <= TICK_STEP_RST;
            q.rise <= RISE_RST;
            q.fall <= FALL_RST;
        end
        else
            q <= d;
    end

    assign prdata = q.prdata;
    assign pready = q.pready;
    assign ramp_level = q.cnt;
    assign ramp_busy = q.busy;

    fall_reset_value_a: assert property (@(posedge pclk)
        $rose(presetn) |-> q.fall == FALL_RST && q.tick_step == TICK_STEP_RST)
        else $error("ramp registers left reset with wrong values");
    config_write_bank_a: assert property (@(posedge pclk) disable iff (!presetn)
        !$stable(q.fall) |-> $past(wr_en) && $past(q.bank) == RAMP_BANK && $past(idx) == IDX_FALL)
        else $error("fall register changed without a bank 3 write");
    reserved_read_zero_a: assert property (@(posedge pclk) disable iff (!presetn)
        (psel && !penable && !pwrite && q.bank == RAMP_BANK && idx > IDX_FALL) |=> pready && prdata == 32'h0000_0000)
        else $error("reserved ramp bank location read nonzero");
    step_size_a: assert property (@(posedge pclk) disable iff (!presetn)
        (advance && q.dir_up && up_sum < {1'b0, power_level_adjust}) |=> q.cnt == $past(q.cnt) + (9'd1 << $past(q.tick_step[1:0])))
        else $error("ramp step differs from step field");
    step_down_a: assert property (@(posedge pclk) disable iff (!presetn)
        (advance && !q.dir_up && {1'b0, q.cnt} > step) |=> q.cnt < $past(q.cnt))
        else $error("ramp-down did not decrement");
    rise_spacing_a: assert property (@(posedge pclk) disable iff (!presetn)
        (q.dir_up && $changed(q.cnt) && $past(q.dir_up) && $past(ramp_up_req) == $past(q.dir_up))
        |-> $past(tick) && {1'b0, $past(q.intv)} + 8'd1 >= {1'b0, $past(q.rise)})
        else $error("ramp-up stepped before rise interval");
    fall_spacing_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!q.dir_up && $changed(q.cnt) && !$past(q.dir_up) && $past(ramp_up_req) == $past(q.dir_up))
        |-> $past(tick) && {1'b0, $past(q.intv)} + 8'd1 >= {1'b0, $past(q.fall)})
        else $error("ramp-down stepped before fall interval");
    end_hold_a: assert property (@(posedge pclk) disable iff (!presetn)
        (!q.dir_up && !ramp_up_req && q.cnt == 9'h000) |=> q.cnt == 9'h000 && !ramp_busy)
        else $error("counter left zero without a ramp request");
endmodule

// [hdl/ramp_tick_div.sv]
// Base tick divider for the PA ramp counter.
`timescale 1ns/100ps
module ramp_tick_div
    import pa_ramp_pkg::*;
(
    // Clock and reset.
    input wire logic pclk,
    input wire logic presetn,
    // Control and tick.
    input wire logic slow_sel,
    output logic tick
);
    typedef struct packed {
        logic [4:0] cnt;
        logic tick;
    } div_state_t;

    div_state_t q, d;
    logic [4:0] limit;

    always_comb
    begin
        d = q;
        limit = slow_sel ? 5'(TICK_DIV_SLOW - 6'd1) : 5'(TICK_DIV_FAST - 6'd1);
        d.tick = 1'b0;
        if (q.cnt == 5'd0)
        begin
            d.tick = 1'b1;
            d.cnt = limit;
        end
        else if (q.cnt > limit)
        begin
            // Drop a long slow count at once when the fast tick is selected.
            d.cnt = limit;
        end
        else
        begin
            d.cnt = q.cnt - 5'd1;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            q <= '0;
        else
            q <= d;
    end

    assign tick = q.tick;

    fast_tick_period_a: assert property (@(posedge pclk) disable iff (!presetn)
        (q.tick && !$past(slow_sel)) |=> !q.tick ##1 q.tick)
        else $error("fast tick period is not two cycles");
    slow_tick_gap_a: assert property (@(posedge pclk) disable iff (!presetn)
        (q.tick && slow_sel) ##1 slow_sel[*8] |-> !$past(q.tick))
        else $error("slow tick came too soon");
endmodule

// [include/pa_ramp_pkg.sv]
// Package with the register map, reset values and timing counts of the PA ramp controller.
package pa_ramp_pkg;
    // Register indices; the APB byte address is four times the index.
    localparam logic [6:0] IDX_BANK_SEL = 7'h00;
    localparam logic [6:0] IDX_TICK_STEP = 7'h41;
    localparam logic [6:0] IDX_RISE = 7'h42;
    localparam logic [6:0] IDX_FALL = 7'h43;
    localparam logic [6:0] IDX_LEVEL_LO = 7'h01;
    localparam logic [6:0] IDX_LEVEL_HI = 7'h02;
    // Bank codes.
    localparam logic [7:0] RAMP_BANK = 8'h03;
    localparam logic [7:0] STATUS_BANK = 8'h00;
    // Field positions of the tick and step register.
    localparam int TICK_SEL_BIT = 2;
    localparam int STEP_LSB = 0;
    // Reset values.
    localparam logic [7:0] BANK_SEL_RST = 8'h00;
    localparam logic [2:0] TICK_STEP_RST = 3'h0;
    localparam logic [6:0] RISE_RST = 7'h00;
    localparam logic [6:0] FALL_RST = 7'h01;
    // Base tick periods in master clock cycles.
    localparam logic [5:0] TICK_DIV_FAST = 6'd2;
    localparam logic [5:0] TICK_DIV_SLOW = 6'd32;
    // Ramp counter limits.
    localparam logic [8:0] LEVEL_MAX = 9'h1ff;
endpackage
